//--- src/sdc_device.sv
// Purpose: Chained SPI target: pass-through with ID decrement and register access
// Assumes: SCLK, select and MOSI come from another domain and are sampled
// Notes:   Register storage lives outside; writes leave through a small buffer
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Small buffer with valid and ready on both sides
module sdc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = sdc_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input logic clock,
   input logic rst,
   // Fill side
   input logic in_valid,
   output logic in_ready,
   input logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
         end
         if (pop)
         begin
            rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
         end
         count <= count + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Forward every bit unchanged except device ID.
// - Forwarded device ID is received value minus one.
// - Received ID zero selects this device.
// - Selected device handles address and data normally.
// - Controller places ID bit-reversed in control byte.
// - Up to sixteen targets; target n uses ID n.
// - Bit7 broadcast, bit6 read, bits5-4 zero.
// - Broadcast write updates every device.
// - Addressed write updates only ID-zero device.
// - Controller slows SCLK as chain grows. Here SCLK_HALF is a fixed parameter, whatever the chain length.
// - Control, address, data bytes; MSB first, rising edge.
// - MISO driven only during addressed read data byte.
// - Early select release aborts; select restarts framing.
module sdc_device (
   // Clock and reset
   input logic clock,
   input logic rst,
   // Serial link
   sdc_link_if.device link,
   // Register write stream
   output logic wr_valid,
   input logic wr_ready,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   output logic wr_room,
   // Register read port
   output logic [7:0] rd_addr,
   input logic [7:0] rd_data,
   // Status
   output logic selected,
   output logic packet_abort
);
   typedef enum logic [2:0] {
      SDC_IDLE = 3'b001,
      SDC_FRAME = 3'b010,
      SDC_DONE = 3'b100
   } sdc_dev_state_t;

   sdc_dev_state_t state;
   logic sclk_s1, sclk_s2, sclk_s3;
   logic sel_s1, sel_s2, sel_s3;
   logic mosi_s1, mosi_s2;
   logic rise, fall, active, sel_fall, sel_rise;
   logic [4:0] bit_cnt;
   logic [6:0] shift_in;
   logic borrow;
   logic cid_nonzero;
   logic cid_phase;
   logic ctrl_bcast, ctrl_read;
   logic load_pending;
   logic miso_drive;
   logic [7:0] miso_shift;
   logic push_valid;
   logic [15:0] push_data;
   logic [15:0] pop_data;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         sel_s1 <= 1'b1;
         sel_s2 <= 1'b1;
         sel_s3 <= 1'b1;
         mosi_s1 <= 1'b0;
         mosi_s2 <= 1'b0;
      end
      else
      begin
         sclk_s1 <= link.sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         sel_s1 <= link.select_n;
         sel_s2 <= sel_s1;
         sel_s3 <= sel_s2;
         mosi_s1 <= link.mosi;
         mosi_s2 <= mosi_s1;
      end
   end

   assign rise = sclk_s2 & ~sclk_s3;
   assign fall = ~sclk_s2 & sclk_s3;
   assign active = ~sel_s2;
   assign sel_fall = ~sel_s2 & sel_s3;
   assign sel_rise = sel_s2 & ~sel_s3;
   assign cid_phase = (state == SDC_FRAME) && (bit_cnt >= sdc_pkg::CNT_CID_FIRST)
                      && (bit_cnt <= sdc_pkg::CNT_CID_LAST);

   ////////////////////////////////////////////////////////////////////////////
   // Framing state
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state <= SDC_IDLE;
         bit_cnt <= sdc_pkg::CNT_RESET;
      end
      else if (!active)
      begin
         state <= SDC_IDLE;
         bit_cnt <= sdc_pkg::CNT_RESET;
      end
      else
      begin
         case (state)
            SDC_IDLE:
            begin
               if (sel_fall)
               begin
                  state <= SDC_FRAME;
                  bit_cnt <= sdc_pkg::CNT_RESET;
               end
            end
            SDC_FRAME:
            begin
               if (rise)
               begin
                  bit_cnt <= bit_cnt + 5'h01;
                  if (bit_cnt == sdc_pkg::CNT_DATA_LAST)
                  begin
                     state <= SDC_DONE;
                  end
               end
            end
            SDC_DONE:
            begin
               if (fall && bit_cnt == sdc_pkg::CNT_DONE)
               begin
                  bit_cnt <= sdc_pkg::CNT_RESET;
               end
            end
            default:
            begin
               state <= SDC_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pass-through with serial decrement of the chain device ID
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         link.chain_data_out <= 1'b0;
      end
      else
      begin
         link.chain_data_out <= mosi_s2 ^ (cid_phase & borrow);
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst || !active || state == SDC_IDLE)
      begin
         borrow <= 1'b1;
         cid_nonzero <= 1'b0;
      end
      else if (rise && cid_phase)
      begin
         borrow <= borrow & ~mosi_s2;
         cid_nonzero <= cid_nonzero | mosi_s2;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte capture and command decode
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         shift_in <= 7'h00;
         ctrl_bcast <= 1'b0;
         ctrl_read <= 1'b0;
         selected <= 1'b0;
         rd_addr <= sdc_pkg::BYTE_RESET;
      end
      else if (!active)
      begin
         selected <= 1'b0;
         ctrl_read <= 1'b0;
         ctrl_bcast <= 1'b0;
      end
      else if (rise && state == SDC_FRAME)
      begin
         shift_in <= {shift_in[5:0], mosi_s2};
         if (bit_cnt == sdc_pkg::CNT_CTRL_LAST)
         begin
            ctrl_bcast <= shift_in[sdc_pkg::CTRL_BCAST_BIT - 1];
            ctrl_read <= shift_in[sdc_pkg::CTRL_READ_BIT - 1];
            selected <= ~(cid_nonzero | mosi_s2);
         end
         if (bit_cnt == sdc_pkg::CNT_ADDR_LAST)
         begin
            rd_addr <= {shift_in, mosi_s2};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write issue: broadcast writes always, addressed writes only when selected
   assign push_valid = rise && active && state == SDC_FRAME
                       && bit_cnt == sdc_pkg::CNT_DATA_LAST && !ctrl_read
                       && (ctrl_bcast || selected);
   assign push_data = {rd_addr, shift_in, mosi_s2};

   sdc_fifo #(
      .WIDTH(16),
      .DEPTH(sdc_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .clock(clock),
      .rst(rst),
      .in_valid(push_valid),
      .in_ready(wr_room),
      .in_data(push_data),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(pop_data)
   );

   assign wr_addr = pop_data[15:8];
   assign wr_data = pop_data[7:0];

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         packet_abort <= 1'b0;
      end
      else
      begin
         packet_abort <= sel_rise && state == SDC_FRAME
                         && bit_cnt != sdc_pkg::CNT_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data on the shared MISO line
   always_ff @(posedge clock)
   begin
      if (rst || !active)
      begin
         load_pending <= 1'b0;
         miso_drive <= 1'b0;
         miso_shift <= sdc_pkg::BYTE_RESET;
      end
      else if (load_pending)
      begin
         load_pending <= 1'b0;
         miso_drive <= 1'b1;
         miso_shift <= rd_data;
      end
      else if (rise && state == SDC_FRAME && bit_cnt == sdc_pkg::CNT_ADDR_LAST)
      begin
         load_pending <= ctrl_read & selected;
      end
      else if (fall && miso_drive)
      begin
         if (bit_cnt == sdc_pkg::CNT_DONE)
         begin
            miso_drive <= 1'b0;
         end
         else if (bit_cnt >= sdc_pkg::CNT_SHIFT_FIRST)
         begin
            miso_shift <= {miso_shift[6:0], 1'b0};
         end
      end
   end

   assign link.miso_out = miso_shift[7];
   assign link.miso_oe_n = ~miso_drive;
endmodule

//--- src/sdc_pkg.sv
// Purpose: Shared constants for the SPI daisy-chain target and controller
// Assumes: 125 MHz system clock, 8-bit bytes, three-byte packets
// Notes:   Control byte carries the chain device ID bit-reversed in bits 3..0
package sdc_pkg;
   // Packet framing
   localparam int BYTE_BITS = 8;
   localparam int PACKET_BITS = 24;
   localparam int ID_W = 4;
   localparam int CHAIN_MAX = 16;
   // Control byte layout
   localparam int CTRL_BCAST_BIT = 7;
   localparam int CTRL_READ_BIT = 6;
   localparam int CTRL_RSVD_HI = 5;
   localparam int CTRL_RSVD_LO = 4;
   localparam logic [1:0] CTRL_RSVD_VAL = 2'h0;
   // Bit counter positions (rising edges already seen)
   localparam logic [4:0] CNT_CID_FIRST = 5'h04;
   localparam logic [4:0] CNT_CID_LAST = 5'h07;
   localparam logic [4:0] CNT_CTRL_LAST = 5'h07;
   localparam logic [4:0] CNT_ADDR_LAST = 5'h0F;
   localparam logic [4:0] CNT_DATA_FIRST = 5'h10;
   localparam logic [4:0] CNT_DATA_LAST = 5'h17;
   localparam logic [4:0] CNT_DONE = 5'h18;
   localparam logic [4:0] CNT_SHIFT_FIRST = 5'h11;
   // Reset values
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [4:0] CNT_RESET = 5'h00;
   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SCLK_PERIOD_NS = 80;
   localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int GAP_NS = 80;
   localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Buffering
   localparam int FIFO_DEPTH = 2;
endpackage

//--- src/sdc_link_if.sv
// Purpose: Serial link between the chain controller and one chained target
// Assumes: Shared MISO idles high when no target drives it
// Notes:   The bench joins several links to build a longer chain
`timescale 1ns/1ns
interface sdc_link_if;
   logic sclk;
   logic select_n;
   logic mosi;
   logic chain_data_out;
   logic miso_out;
   logic miso_oe_n;
   logic miso;

   // Resolved level of the shared read line
   assign miso = miso_oe_n ? 1'b1 : miso_out;

   modport device (
      input sclk,
      input select_n,
      input mosi,
      output chain_data_out,
      output miso_out,
      output miso_oe_n
   );
   modport controller (
      output sclk,
      output select_n,
      output mosi,
      input miso
   );
endinterface

//--- src/sdc_controller.sv
// Purpose: Chain controller: builds packets and clocks them onto the link
// Assumes: Commands arrive through a two-entry buffer with back-pressure
// Notes:   Read data is sampled at the end of each high phase of SCLK
`timescale 1ns/1ns
module sdc_controller #(
   parameter int SCLK_HALF = sdc_pkg::SCLK_HALF_CYC,
   parameter int GAP = sdc_pkg::GAP_CYC
) (
   // Clock and reset
   input logic clock,
   input logic rst,
   // Serial link
   sdc_link_if.controller link,
   // Command stream
   input logic cmd_valid,
   output logic cmd_ready,
   input logic cmd_broadcast,
   input logic cmd_read,
   input logic [3:0] cmd_id,
   input logic [7:0] cmd_addr,
   input logic [7:0] cmd_data,
   // Read answer
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic busy
);
   typedef enum logic [3:0] {
      SDC_C_IDLE = 4'b0001,
      SDC_C_LOW = 4'b0010,
      SDC_C_HIGH = 4'b0100,
      SDC_C_GAP = 4'b1000
   } sdc_ctl_state_t;

   sdc_ctl_state_t state;
   logic [15:0] div_cnt;
   logic tick;
   logic gap_done;
   logic miso_s1, miso_s2;
   logic [4:0] bit_cnt;
   logic [23:0] shift_out;
   logic is_read;
   logic [7:0] rx;
   logic q_valid;
   logic q_pop;
   logic [21:0] q_data;
   logic [21:0] cmd_word;
   logic [7:0] ctrl_byte;

   assign cmd_word = {cmd_broadcast, cmd_read, cmd_id, cmd_addr, cmd_data};

   sdc_fifo #(
      .WIDTH(22),
      .DEPTH(sdc_pkg::FIFO_DEPTH)
   ) u_cmd_fifo (
      .clock(clock),
      .rst(rst),
      .in_valid(cmd_valid),
      .in_ready(cmd_ready),
      .in_data(cmd_word),
      .out_valid(q_valid),
      .out_ready(q_pop),
      .out_data(q_data)
   );

   // Reads ignore the broadcast flag; ID goes in bit-reversed
   assign ctrl_byte = {q_data[21] & ~q_data[20], q_data[20], sdc_pkg::CTRL_RSVD_VAL,
                       q_data[16], q_data[17], q_data[18], q_data[19]};
   assign q_pop = (state == SDC_C_IDLE) && q_valid;
   assign busy = (state != SDC_C_IDLE) || q_valid;

   ////////////////////////////////////////////////////////////////////////////
   // Half-period divider for SCLK and the inter-packet gap
   assign tick = (div_cnt == 16'(SCLK_HALF - 1));
   assign gap_done = (div_cnt == 16'(GAP - 1));

   always_ff @(posedge clock)
   begin
      if (rst || state == SDC_C_IDLE)
      begin
         div_cnt <= 16'h0000;
      end
      else if ((state == SDC_C_GAP) ? gap_done : tick)
      begin
         div_cnt <= 16'h0000;
      end
      else
      begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         miso_s1 <= 1'b1;
         miso_s2 <= 1'b1;
      end
      else
      begin
         miso_s1 <= link.miso;
         miso_s2 <= miso_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Packet sequencer
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state <= SDC_C_IDLE;
         link.sclk <= 1'b0;
         link.select_n <= 1'b1;
         link.mosi <= 1'b0;
         bit_cnt <= sdc_pkg::CNT_RESET;
         shift_out <= 24'h00_0000;
         is_read <= 1'b0;
         rx <= sdc_pkg::BYTE_RESET;
         rsp_valid <= 1'b0;
         rsp_data <= sdc_pkg::BYTE_RESET;
      end
      else
      begin
         rsp_valid <= 1'b0;
         case (state)
            SDC_C_IDLE:
            begin
               if (q_valid)
               begin
                  shift_out <= {ctrl_byte, q_data[15:0]};
                  link.mosi <= ctrl_byte[7];
                  is_read <= q_data[20];
                  link.select_n <= 1'b0;
                  bit_cnt <= sdc_pkg::CNT_RESET;
                  state <= SDC_C_LOW;
               end
            end
            SDC_C_LOW:
            begin
               if (tick)
               begin
                  link.sclk <= 1'b1;
                  state <= SDC_C_HIGH;
               end
            end
            SDC_C_HIGH:
            begin
               if (tick)
               begin
                  link.sclk <= 1'b0;
                  bit_cnt <= bit_cnt + 5'h01;
                  shift_out <= {shift_out[22:0], 1'b0};
                  link.mosi <= shift_out[22];
                  if (bit_cnt >= sdc_pkg::CNT_DATA_FIRST)
                  begin
                     rx <= {rx[6:0], miso_s2};
                  end
                  if (bit_cnt == sdc_pkg::CNT_DATA_LAST)
                  begin
                     link.select_n <= 1'b1;
                     link.mosi <= 1'b0;
                     rsp_valid <= is_read;
                     rsp_data <= {rx[6:0], miso_s2};
                     state <= SDC_C_GAP;
                  end
                  else
                  begin
                     state <= SDC_C_LOW;
                  end
               end
            end
            SDC_C_GAP:
            begin
               if (gap_done)
               begin
                  state <= SDC_C_IDLE;
               end
            end
            default:
            begin
               state <= SDC_C_IDLE;
            end
         endcase
      end
   end
endmodule

//--- verif/sdc_link_checker.sv
// Purpose: Assertions on the link between the controller and the first target
// Assumes: All link signals are sampled by the system clock
// Notes:   Helper counters measure high-phase length, frame size and read drive time
`timescale 1ns/1ns
module sdc_link_checker #(
   parameter int SCLK_HALF = sdc_pkg::SCLK_HALF_CYC
) (
   // System side
   input logic clock,
   input logic rst,
   // Link
   input logic sclk,
   input logic select_n,
   input logic mosi,
   input logic chain_data_out,
   input logic miso_out,
   input logic miso_oe_n,
   input logic miso
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);

   logic [7:0] hi_cnt;
   logic [4:0] rises;
   logic [8:0] low_cnt;
   logic sclk_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Length of the current high phase of the serial clock
   always_ff @(posedge clock)
   begin
      hi_cnt <= (sclk && !rst) ? hi_cnt + 8'h01 : 8'h00;
   end

   // Rising serial clock edges seen within the frame
   always_ff @(posedge clock)
   begin
      sclk_q <= sclk;
      if (select_n || rst)
         rises <= 5'h00;
      else if (sclk && !sclk_q)
         rises <= rises + 5'h01;
   end

   // Cycles the read line has been driven
   always_ff @(posedge clock)
   begin
      low_cnt <= (miso_oe_n || rst) ? 9'h000 : low_cnt + 9'h001;
   end

   ////////////////////////////////////////////////////////////////////////////////
   AST_SCLK_HIGH_PHASE: assert property ($fell(sclk) |-> hi_cnt == SCLK_HALF)
      else $error("serial clock high phase has wrong length");
   AST_SCLK_LOW_FIRST: assert property ($fell(select_n) |-> !sclk [*5])
      else $error("serial clock rose too soon after select");
   AST_FRAME_LENGTH: assert property ($rose(select_n) |-> rises == 5'h18)
      else $error("frame did not carry 24 bits");
   AST_MOSI_HOLD: assert property (sclk && $past(sclk) |-> $stable(mosi))
      else $error("data changed while serial clock high");
   AST_SCLK_STILL: assert property (select_n |-> !sclk)
      else $error("serial clock high outside a frame");
   AST_MOSI_IDLE: assert property (select_n |-> !mosi)
      else $error("data line not idle outside a frame");
   AST_MISO_QUIET: assert property (select_n [*8] |-> miso_oe_n)
      else $error("read line driven while deselected");
   AST_MISO_WINDOW: assert property ($rose(miso_oe_n)
      |-> low_cnt inside {[16 * SCLK_HALF:18 * SCLK_HALF]})
      else $error("read line driven for wrong span");
   AST_MISO_BOUND: assert property (low_cnt <= 9'(18 * SCLK_HALF))
      else $error("read line driven too long");
   AST_MISO_SETTLE: assert property (!miso_oe_n && !$past(miso_oe_n)
      && $changed(miso_out) |-> !sclk)
      else $error("read data changed while serial clock high");
   AST_CDO_IDLE: assert property (select_n [*6] |-> chain_data_out == $past(mosi, 3))
      else $error("forwarded data differs outside a frame");
endmodule

//--- verif/test_spi_daisy_chain_addressing.sv
// Purpose: Controller driving a chain of two targets, self-checking
// Assumes: Targets share clock and select; read line resolved by the bench
// Notes:   Drivers note expectations in queues; monitors match them in order
`timescale 1ns/1ns
module test_spi_daisy_chain_addressing;
   localparam int HALF = 11;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic cut = 1'b0;
   logic stall = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   logic cmd_broadcast = 1'b0;
   logic cmd_read = 1'b0;
   logic [3:0] cmd_id = 4'h0;
   logic [7:0] cmd_addr = 8'h00;
   logic [7:0] cmd_data = 8'h00;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic busy;
   logic [1:0] wr_valid;
   logic [1:0] wr_ready = 2'h0;
   logic [1:0] wr_room;
   logic [1:0] pab;
   logic [1:0] sel;
   logic [7:0] wr_addr [2];
   logic [7:0] wr_data [2];
   logic [7:0] rd_addr [2];
   logic [7:0] rd_data [2];
   logic [48:0] q_w0 [$];
   logic [48:0] q_w1 [$];
   logic [48:0] q_rd [$];
   logic [48:0] q_wire [$];
   logic [23:0] c_sh = 24'h00_0000;
   logic [23:0] t_sh = 24'h00_0000;
   int bad_count = 0;
   int n_compared = 0;
   int n_abort = 0;

   always #(sdc_pkg::CLK_PERIOD_NS / 2) clock = ~clock;

   ////////////////////////////////////////////////////////////////////////////////
   // Chain wiring: cut forces an early select release at the targets
   sdc_link_if link_c ();
   sdc_link_if link_d0 ();
   sdc_link_if link_d1 ();
   assign link_d0.sclk = link_c.sclk;
   assign link_d0.select_n = link_c.select_n | cut;
   assign link_d0.mosi = link_c.mosi;
   assign link_d1.sclk = link_c.sclk;
   assign link_d1.select_n = link_d0.select_n;
   assign link_d1.mosi = link_d0.chain_data_out;
   assign link_c.chain_data_out = link_d1.chain_data_out;
   assign link_c.miso_oe_n = link_d0.miso_oe_n & link_d1.miso_oe_n;
   assign link_c.miso_out = link_d0.miso_oe_n ? link_d1.miso_out : link_d0.miso_out;
   assign rd_data[0] = rd_addr[0] ^ 8'hA5;
   assign rd_data[1] = rd_addr[1] ^ 8'h3C;

   sdc_controller #(.SCLK_HALF(HALF), .GAP(sdc_pkg::GAP_CYC)) u_sdc_controller (
      .clock(clock), .rst(rst), .link(link_c.controller), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_broadcast(cmd_broadcast), .cmd_read(cmd_read),
      .cmd_id(cmd_id), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy));
   sdc_device u_sdc_device_0 (.clock(clock), .rst(rst), .link(link_d0.device),
      .wr_valid(wr_valid[0]), .wr_ready(wr_ready[0]), .wr_addr(wr_addr[0]),
      .wr_data(wr_data[0]), .wr_room(wr_room[0]), .rd_addr(rd_addr[0]),
      .rd_data(rd_data[0]), .selected(sel[0]), .packet_abort(pab[0]));
   sdc_device u_sdc_device_1 (.clock(clock), .rst(rst), .link(link_d1.device),
      .wr_valid(wr_valid[1]), .wr_ready(wr_ready[1]), .wr_addr(wr_addr[1]),
      .wr_data(wr_data[1]), .wr_room(wr_room[1]), .rd_addr(rd_addr[1]),
      .rd_data(rd_data[1]), .selected(sel[1]), .packet_abort(pab[1]));
   sdc_link_checker #(.SCLK_HALF(HALF)) u_sdc_link_checker (.clock(clock), .rst(rst),
      .sclk(link_c.sclk), .select_n(link_c.select_n), .mosi(link_c.mosi),
      .chain_data_out(link_d0.chain_data_out), .miso_out(link_d0.miso_out),
      .miso_oe_n(link_d0.miso_oe_n), .miso(link_c.miso));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [48:0] seen, input logic [48:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic take(ref logic [48:0] q [$], input logic [48:0] seen);
      if (q.size() == 0)
         check(seen, ~seen);
      else
         check(seen, q.pop_front());
   endtask

   task automatic wrap_up;
      if (bad_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // One command; keep low means no write is expected to land
   task automatic send(input logic bc, input logic rd, input logic [3:0] id, input logic keep);
      logic [7:0] ctl;
      logic [3:0] nid;
      logic [7:0] a;
      logic [7:0] d;
      a = 8'($urandom);
      d = 8'($urandom);
      ctl = {bc & ~rd, rd, 2'h0, id[0], id[1], id[2], id[3]};
      nid = id - 4'h1;
      q_wire.push_back({rd | ~keep, ctl, a, d, ctl[7:4], nid[0], nid[1], nid[2], nid[3], a, d});
      if (rd)
         q_rd.push_back({41'h0, (id == 4'h0) ? a ^ 8'hA5 : (id == 4'h1) ? a ^ 8'h3C : 8'hFF});
      if (!rd && keep && (bc || id == 4'h0))
         q_w0.push_back({33'h0, a, d});
      if (!rd && keep && (bc || id == 4'h1))
         q_w1.push_back({33'h0, a, d});
      @(negedge clock);
      cmd_valid = 1'b1;
      cmd_broadcast = bc;
      cmd_read = rd;
      cmd_id = id;
      cmd_addr = a;
      cmd_data = d;
      while (cmd_ready !== 1'b1)
         @(negedge clock);
      @(negedge clock);
      cmd_valid = 1'b0;
   endtask

   task automatic idle;
      @(negedge clock);
      while (busy !== 1'b0 || (wr_valid !== 2'h0 && !stall))
         @(negedge clock);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Monitors
   always @(negedge clock) wr_ready <= 2'($urandom) & {2{~stall}};

   always @(posedge clock)
   begin
      if (!rst && wr_valid[0] && wr_ready[0])
         take(q_w0, {33'h0, wr_addr[0], wr_data[0]});
      if (!rst && wr_valid[1] && wr_ready[1])
         take(q_w1, {33'h0, wr_addr[1], wr_data[1]});
      if (!rst && rsp_valid)
         take(q_rd, {41'h0, rsp_data});
      if (!rst)
         n_abort = n_abort + 32'(pab[0]) + 32'(pab[1]);
   end

   always @(posedge link_c.sclk)
   begin
      c_sh <= {c_sh[22:0], link_c.mosi};
      t_sh <= {t_sh[22:0], link_d1.mosi};
   end

   // Reads and aborted packets compare the control bytes only
   always @(posedge link_c.select_n)
   begin : wire_mon
      logic [48:0] e;
      logic [48:0] m;
      logic [1:0] s;
      if (!rst && q_wire.size() == 0)
         check(49'h0, 49'h1);
      else if (!rst)
      begin
         e = q_wire.pop_front();
         m = e[48] ? 49'h1_FF00_00FF_0000 : 49'h1_FFFF_FFFF_FFFF;
         check({e[48], c_sh, t_sh} & m, e & m);
         // Target selection follows the sent ID; a cut frame leaves none selected
         s = ~{2{cut}} & {e[43:40] == 4'h8, e[43:40] == 4'h0};
         check({47'h0, sel}, {47'h0, s});
      end
   end

   initial
   begin
      repeat (60000) @(posedge clock);
      bad_count++;
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(51));
      repeat (10) @(negedge clock);
      rst = 1'b0;
      repeat (8) @(negedge clock);
      for (int i = 0; i < 16; i++)
      begin
         send(1'b0, 1'b0, 4'(i), 1'b1);
         send(1'(i), 1'b1, 4'(i), 1'b1);
      end
      for (int i = 0; i < 4; i++)
         send(1'b1, 1'b0, 4'($urandom), 1'b1);
      idle();
      // Early select release in the address byte, then a clean packet
      send(1'b0, 1'b0, 4'h0, 1'b0);
      while (link_c.select_n !== 1'b0)
         @(negedge clock);
      repeat (24 * HALF) @(negedge clock);
      cut = 1'b1;
      idle();
      cut = 1'b0;
      check({17'h0, n_abort}, 49'h2);
      send(1'b0, 1'b0, 4'h0, 1'b1);
      // Stalled register side: third write finds the buffer full
      stall = 1'b1;
      send(1'b0, 1'b0, 4'h1, 1'b1);
      send(1'b0, 1'b0, 4'h1, 1'b1);
      send(1'b0, 1'b0, 4'h1, 1'b0);
      idle();
      check({48'h0, wr_room[1]}, 49'h0);
      stall = 1'b0;
      idle();
      repeat (4) @(negedge clock);
      check({17'h0, q_w0.size() + q_w1.size() + q_rd.size() + q_wire.size()}, 49'h0);
      wrap_up();
   end
endmodule
